// File: design/ict_pkg.sv
// Constants, types and register map for the I-channel offset and gain trims
package ict_pkg;

  // Printed register indices; byte address is four times the index
  localparam int ICT_IDX_OFS  = 2;
  localparam int ICT_IDX_FS   = 3;
  localparam int ICT_IDX_STAT = 4;
  localparam logic [5:0] ICT_SEL_OFS  = 6'(ICT_IDX_OFS);
  localparam logic [5:0] ICT_SEL_FS   = 6'(ICT_IDX_FS);
  localparam logic [5:0] ICT_SEL_STAT = 6'(ICT_IDX_STAT);
  localparam int ICT_ADDR_LSB = 2;
  localparam int ICT_ADDR_MSB = 7;

  // Field positions
  localparam int ICT_OFS_MAG_MSB = 15;
  localparam int ICT_OFS_MAG_LSB = 8;
  localparam int ICT_OFS_SIGN    = 7;
  localparam int ICT_FS_MSB      = 15;
  localparam int ICT_FS_LSB      = 7;
  localparam int ICT_ONES_MSB    = 6;
  localparam logic [6:0] ICT_ONES = 7'h7f;

  // Reset values
  localparam logic [15:0] ICT_OFS_RST = 16'h007f;
  localparam logic [15:0] ICT_FS_RST  = 16'h807f;
  localparam logic [8:0]  ICT_FS_MID  = 9'h100;

  // Recommended full-scale code window, and the top full-scale code
  localparam logic [8:0] ICT_FS_REC_LO = 9'h0c0;
  localparam logic [8:0] ICT_FS_REC_HI = 9'h1c0;
  localparam logic [8:0] ICT_FS_TOP    = 9'h1ff;

  // Analog mapping figures
  localparam int ICT_OFS_STEP_UV = 176;
  localparam int ICT_FS_MIN_MV   = 560;
  localparam int ICT_FS_MAX_MV   = 840;
  localparam int ICT_FS_SPAN_MV  = ICT_FS_MAX_MV - ICT_FS_MIN_MV;
  localparam int ICT_FS_CODE_MAX = 511;

  // Status bits
  localparam int ICT_ST_OFS_ONES = 0;
  localparam int ICT_ST_FS_ONES  = 1;
  localparam int ICT_ST_FS_RANGE = 2;
  localparam int ICT_ST_W        = 3;

  // AHB-Lite codes
  localparam logic [1:0] ICT_HTRANS_NONSEQ = 2'b10;

  typedef struct packed {
    logic [7:0] mag;
    logic       neg;
    logic [8:0] code;
  } ict_trim_s;

  typedef enum logic [1:0] {
    ICT_PH_IDLE = 2'b00,
    ICT_PH_WR   = 2'b01,
    ICT_PH_RD   = 2'b10
  } ict_phase_e;

endpackage : ict_pkg

// File: design/ict_trim_map.sv
// Maps trim codes to offset in microvolts and full-scale in millivolts
module ict_trim_map (
  // Trim codes
  input  ict_pkg::ict_trim_s trim,
  // Analog targets
  output logic signed [16:0] ofs_uv,
  output logic        [9:0]  fs_mv
);

  logic [16:0] mag_uv;
  logic [17:0] prod;

  // Linear offset, 176 uV per step, sign applied last
  always_comb begin
    mag_uv = 17'(int'(trim.mag) * ict_pkg::ICT_OFS_STEP_UV);
    ofs_uv = trim.neg ? -$signed(mag_uv) : $signed(mag_uv);
  end

  // Monotonic gain: 560 mV at zero to 840 mV at the top code
  always_comb begin
    prod  = 18'(int'(trim.code) * ict_pkg::ICT_FS_SPAN_MV);
    fs_mv = 10'(ict_pkg::ICT_FS_MIN_MV + int'(prod) / ict_pkg::ICT_FS_CODE_MAX);
  end

endmodule : ict_trim_map

// File: design/ict_regs.sv
// AHB-Lite register bank for the I-channel offset and full-scale trims
//
// Register access over AHB-Lite was left to the implementer.
module ict_regs (
  // Clock and reset
  input  wire  logic                CLK,
  input  wire  logic                RSTN,
  // AHB-Lite slave
  input  wire  logic                HSEL,
  input  wire  logic [31:0]         HADDR,
  input  wire  logic [1:0]          HTRANS,
  input  wire  logic                HWRITE,
  input  wire  logic [2:0]          HSIZE,
  input  wire  logic [31:0]         HWDATA,
  input  wire  logic                HREADY,
  output logic       [31:0]         HRDATA,
  output logic                      HREADYOUT,
  output logic                      HRESP,
  // Trim outputs to the analog front end
  output logic       [7:0]          OFS_MAG,
  output logic                      OFS_NEG,
  output logic       [8:0]          FS_CODE,
  output logic signed [16:0]        OFS_UV,
  output logic       [9:0]          FS_MV
);

  ict_pkg::ict_phase_e          phase, next_phase;
  logic [5:0]                   dp_sel, next_dp_sel;
  ict_pkg::ict_trim_s           trim, next_trim;
  logic [ict_pkg::ICT_ST_W-1:0] stat, next_stat;
  logic [31:0]                  rdata, next_rdata;
  logic signed [16:0]           ofs_uv_q, map_ofs_uv;
  logic [9:0]                   fs_mv_q, map_fs_mv;
  logic                         addr_ok;
  logic [5:0]                   addr_sel;
  logic [8:0]                   wr_code;

  // Reset image of the trims, taken from the documented reset words
  localparam ict_pkg::ict_trim_s TRIM_RST = '{
    mag:  ict_pkg::ICT_OFS_RST[ict_pkg::ICT_OFS_MAG_MSB:ict_pkg::ICT_OFS_MAG_LSB],
    neg:  ict_pkg::ICT_OFS_RST[ict_pkg::ICT_OFS_SIGN],
    code: ict_pkg::ICT_FS_RST[ict_pkg::ICT_FS_MSB:ict_pkg::ICT_FS_LSB]
  };

  // Analog mapping of the held codes
  ict_trim_map u_map (
    .trim   (trim),
    .ofs_uv (map_ofs_uv),
    .fs_mv  (map_fs_mv)
  );

  // Address phase decode; any size is accepted, a narrow write still loads the word
  always_comb begin
    addr_ok  = HSEL && (HTRANS == ict_pkg::ICT_HTRANS_NONSEQ) && HREADY;
    addr_sel = HADDR[ict_pkg::ICT_ADDR_MSB:ict_pkg::ICT_ADDR_LSB];
    wr_code  = HWDATA[ict_pkg::ICT_FS_MSB:ict_pkg::ICT_FS_LSB];
  end

  // Bus phase tracking and read data; trims never read back
  always_comb begin
    next_phase  = ict_pkg::ICT_PH_IDLE;
    next_dp_sel = dp_sel;
    next_rdata  = 32'h0;
    if (addr_ok) begin
      next_phase  = HWRITE ? ict_pkg::ICT_PH_WR : ict_pkg::ICT_PH_RD;
      next_dp_sel = addr_sel;
      if (!HWRITE && addr_sel == ict_pkg::ICT_SEL_STAT) begin
        next_rdata = {29'h0, stat};
      end
    end
  end

  // Trim and status updates in the write data phase
  always_comb begin
    next_trim = trim;
    next_stat = stat;
    case (phase)
      ict_pkg::ICT_PH_WR: begin
        case (dp_sel)
          ict_pkg::ICT_SEL_OFS: begin
            next_trim.mag = HWDATA[ict_pkg::ICT_OFS_MAG_MSB:ict_pkg::ICT_OFS_MAG_LSB];
            next_trim.neg = HWDATA[ict_pkg::ICT_OFS_SIGN];
          end
          ict_pkg::ICT_SEL_FS: begin
            // Applied at once; no calibration request is raised
            next_trim.code = wr_code;
          end
          ict_pkg::ICT_SEL_STAT: begin
            next_stat = stat & ~HWDATA[ict_pkg::ICT_ST_W-1:0];
          end
          default: begin
            next_stat = stat;
          end
        endcase
        // Sticky flags for host slips; set after clear so a set wins
        if (dp_sel == ict_pkg::ICT_SEL_OFS
            && HWDATA[ict_pkg::ICT_ONES_MSB:0] != ict_pkg::ICT_ONES) begin
          next_stat[ict_pkg::ICT_ST_OFS_ONES] = 1'b1;
        end
        if (dp_sel == ict_pkg::ICT_SEL_FS) begin
          if (HWDATA[ict_pkg::ICT_ONES_MSB:0] != ict_pkg::ICT_ONES) begin
            next_stat[ict_pkg::ICT_ST_FS_ONES] = 1'b1;
          end
          if (wr_code < ict_pkg::ICT_FS_REC_LO || wr_code > ict_pkg::ICT_FS_REC_HI) begin
            next_stat[ict_pkg::ICT_ST_FS_RANGE] = 1'b1;
          end
        end
      end
      ict_pkg::ICT_PH_IDLE, ict_pkg::ICT_PH_RD: begin
        next_trim = trim;
      end
      default: begin
        next_trim = trim;
      end
    endcase
  end

  // Registers; trims hold until rewritten or reset
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      phase    <= ict_pkg::ICT_PH_IDLE;
      dp_sel   <= 6'h00;
      trim     <= TRIM_RST;
      stat     <= 3'h0;
      rdata    <= 32'h0;
      ofs_uv_q <= 17'sh00000;
      fs_mv_q  <= 10'h000;
    end else begin
      phase    <= next_phase;
      dp_sel   <= next_dp_sel;
      trim     <= next_trim;
      stat     <= next_stat;
      rdata    <= next_rdata;
      ofs_uv_q <= map_ofs_uv;
      fs_mv_q  <= map_fs_mv;
    end
  end

  // Zero-wait slave, always OKAY; other outputs all from flops
  assign HRDATA    = rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign OFS_MAG   = trim.mag;
  assign OFS_NEG   = trim.neg;
  assign FS_CODE   = trim.code;
  assign OFS_UV    = ofs_uv_q;
  assign FS_MV     = fs_mv_q;

  // Checks below watch only what this block drives
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  logic [16:0] ofs_abs;
  always_comb begin
    ofs_abs = OFS_UV[16] ? 17'(-OFS_UV) : 17'(OFS_UV);
  end

  a_ofs_mag_load: assert property (
    phase == ict_pkg::ICT_PH_WR && dp_sel == ict_pkg::ICT_SEL_OFS
    |=> OFS_MAG == $past(HWDATA[15:8]))
    else $error("offset magnitude not loaded from write");

  a_ofs_step_size: assert property (
    $past(RSTN) |-> ofs_abs == 17'(int'($past(OFS_MAG)) * ict_pkg::ICT_OFS_STEP_UV))
    else $error("offset step is not 176 uV per code");

  a_ofs_sign_sel: assert property (
    $past(RSTN) && $past(OFS_MAG) != 8'h00 |-> OFS_UV[16] == $past(OFS_NEG))
    else $error("offset polarity does not follow sign bit");

  a_fs_code_load: assert property (
    phase == ict_pkg::ICT_PH_WR && dp_sel == ict_pkg::ICT_SEL_FS
    |=> FS_CODE == $past(HWDATA[15:7]))
    else $error("gain code not loaded from bits 15:7");

  a_fs_span_ends: assert property (
    $past(RSTN) |-> FS_MV >= 10'(ict_pkg::ICT_FS_MIN_MV)
      && FS_MV <= 10'(ict_pkg::ICT_FS_MAX_MV)
      && ($past(FS_CODE) != ict_pkg::ICT_FS_TOP || FS_MV == 10'(ict_pkg::ICT_FS_MAX_MV))
      && ($past(FS_CODE) != 9'h000 || FS_MV == 10'(ict_pkg::ICT_FS_MIN_MV)))
    else $error("full-scale outside 560 to 840 mV mapping");

  a_gain_no_recal: assert property (
    phase == ict_pkg::ICT_PH_WR && dp_sel == ict_pkg::ICT_SEL_FS
    |-> HREADYOUT ##1 FS_CODE == $past(HWDATA[15:7]) ##1 FS_MV == $past(map_fs_mv))
    else $error("gain change stalled or delayed");

  a_fs_reset_mid: assert property (@(posedge CLK) disable iff (1'b0)
    !RSTN |=> FS_CODE == ict_pkg::ICT_FS_MID && OFS_MAG == 8'h00 && !OFS_NEG)
    else $error("trims not at reset values after reset");

  a_trim_read_hidden: assert property (
    addr_ok && !HWRITE && addr_sel != ict_pkg::ICT_SEL_STAT |=> HRDATA == 32'h0)
    else $error("trim register contents visible on read");

  c_ofs_write: cover property (
    phase == ict_pkg::ICT_PH_WR && dp_sel == ict_pkg::ICT_SEL_OFS && HWDATA[7]);
  c_fs_write: cover property (
    phase == ict_pkg::ICT_PH_WR && dp_sel == ict_pkg::ICT_SEL_FS);
  c_range_flag: cover property (
    $rose(stat[ict_pkg::ICT_ST_FS_RANGE]));
  c_stat_read: cover property (
    phase == ict_pkg::ICT_PH_RD && dp_sel == ict_pkg::ICT_SEL_STAT && HRDATA != 32'h0);

endmodule : ict_regs

// File: bench/i_channel_offset_gain_regs_test.sv
// Self-checking bench for the I-channel offset and full-scale trim registers
module i_channel_offset_gain_regs_test;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [31:0] A_OFS = 32'(ict_pkg::ICT_IDX_OFS * 4);
  localparam logic [31:0] A_FS  = 32'(ict_pkg::ICT_IDX_FS * 4);
  localparam logic [31:0] A_ST  = 32'(ict_pkg::ICT_IDX_STAT * 4);

  typedef struct {
    logic [31:0] addr;
    logic [15:0] data;
    logic [8:0]  code;
    int          expv;
  } ict_row_s;

  logic               clk = 1'b0;
  logic               rstn = 1'b0;
  logic               hsel = 1'b0;
  logic        [31:0] haddr = 32'h0;
  logic        [1:0]  htrans = 2'b00;
  logic               hwrite = 1'b0;
  logic        [2:0]  hsize = 3'b010;
  logic        [31:0] hwdata = 32'h0;
  logic        [31:0] hrdata;
  logic               hreadyout;
  logic               hresp;
  logic        [7:0]  ofs_mag;
  logic               ofs_neg;
  logic        [8:0]  fs_code;
  logic signed [16:0] ofs_uv;
  logic        [9:0]  fs_mv;
  logic        [31:0] rd;
  int                 mismatches = 0;
  int                 samples_checked = 0;

  // Offset rows hold {sign, magnitude}, full-scale rows the 9-bit code
  ict_row_s rows [9] = '{
    '{A_OFS, 16'hff7f, 9'h0ff, 44880}, '{A_OFS, 16'hffff, 9'h1ff, -44880},
    '{A_OFS, 16'h017f, 9'h001, 176}, '{A_OFS, 16'h80ff, 9'h180, -22528},
    '{A_FS, 16'h007f, 9'h000, 560}, '{A_FS, 16'hffff, 9'h1ff, 840},
    '{A_FS, 16'h607f, 9'h0c0, 665}, '{A_FS, 16'he07f, 9'h1c0, 805},
    '{A_FS, 16'h807f, 9'h100, 700}};

  ict_regs ict_regs_i (
    .CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .OFS_MAG(ofs_mag),
    .OFS_NEG(ofs_neg), .FS_CODE(fs_code), .OFS_UV(ofs_uv), .FS_MV(fs_mv));

  // Clock at 20 MHz
  initial begin
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One single AHB-Lite transfer; waits on hready, only the watchdog ends a hang
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= ict_pkg::ICT_HTRANS_NONSEQ;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  // Trims land at the data edge, analog targets one edge later
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // Reset low for exactly two sampling edges, checked after the first
  task automatic reset_seq();
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    check(32'(fs_code), 32'h100);
    check({23'h0, ofs_neg, ofs_mag}, 32'h0);
    check(32'(ofs_uv), 32'h0);
    @(posedge clk);
    rstn <= 1'b1;
    settle();
    check(32'(fs_mv), 32'd700);
  endtask : reset_seq

  task automatic complete_run();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // Watchdog well beyond the expected hundred or so cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  initial begin
    reset_seq();
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].addr, {16'h0, rows[i].data});
      settle();
      if (rows[i].addr == A_OFS) begin
        check({23'h0, ofs_neg, ofs_mag}, 32'(rows[i].code));
        check(32'(ofs_uv), 32'(rows[i].expv));
      end else begin
        check(32'(fs_code), 32'(rows[i].code));
        check(32'(fs_mv), 32'(rows[i].expv));
      end
    end
    // Write-only trims and an unmapped slot read zero; values persist
    xfer(1'b1, A_ST, 32'h7);
    xfer(1'b0, A_ST, 32'h0);
    check(rd, 32'h0);
    xfer(1'b0, A_OFS, 32'h0);
    check(rd, 32'h0);
    check(32'(hresp), 32'h0);
    xfer(1'b0, A_FS, 32'h0);
    check(rd, 32'h0);
    xfer(1'b0, 32'h20, 32'h0);
    check(rd, 32'h0);
    xfer(1'b1, 32'h20, 32'h0);
    settle();
    check({23'h0, ofs_neg, ofs_mag}, 32'h180);
    check(32'(fs_code), 32'h100);
    // Single writes, an idle cycle apart, breaking host-side rules raise status flags
    xfer(1'b1, A_FS, 32'hffff);
    xfer(1'b1, A_OFS, 32'h0);
    xfer(1'b0, A_ST, 32'h0);
    check(rd, 32'h5);
    xfer(1'b1, A_ST, 32'h7);
    xfer(1'b1, A_FS, 32'h8000);
    xfer(1'b0, A_ST, 32'h0);
    check(rd, 32'h2);
    // Mid-run reset after non-default trims
    xfer(1'b1, A_OFS, 32'hff7f);
    xfer(1'b1, A_FS, 32'hffff);
    reset_seq();
    xfer(1'b0, A_ST, 32'h0);
    check(rd, 32'h0);
    complete_run();
  end

endmodule : i_channel_offset_gain_regs_test
